// *** tlic_core.sv ***
// two-level interrupt controller: enables, levels, pending flags, arbitration, nesting,
// and the grant / return handshake with the cpu core.
// assumes request pulses and core strobes are synchronous to pclk; registers sit behind apb.
`timescale 1ns/10ps
// Summary of operation
// - two levels, each source programmable
// - high request preempts active low routine
// - no preemption by equal or lower level
// - same level: smallest query number wins
// - grant: core pushes pc, loads vector
// - return pops pc, ends active level
// - equal-level request stays pending until later
// - one instruction after return before grant
// - global enable bit 7 masks everything
// - primary enable register source bit layout
// - primary level register bit layout
// - secondary enable register bit layout
// - secondary level register bit layout
// - secondary level bit: one means high
// - fixed vector per query number
// - timer0/1, ext0/1 flags cleared on grant
module tlic_core
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // request set pulses from peripherals, indexed in query order
   input wire logic [tlic_pkg::NUM_SRC-1:0] src_set,
   // cpu core handshake
   input wire logic instr_boundary,
   input wire logic return_from_interrupt,
   output logic irq_take,
   output logic irq_high,
   output logic [3:0] irq_src,
   output logic [15:0] irq_vector,
   // pending flags as seen by peripherals
   output logic [tlic_pkg::NUM_SRC-1:0] pending_flags
);
   // register state
   logic [7:0] en_pri_q, en_pri_d; // primary enable
   logic [7:0] en_sec_q, en_sec_d; // secondary enable
   logic [7:0] lv_pri_q, lv_pri_d; // primary level
   logic [7:0] lv_sec_q, lv_sec_d; // secondary level
   logic [tlic_pkg::NUM_SRC-1:0] flag_q, flag_d; // pending flags
   // nesting state
   logic act_high_q, act_high_d; // high routine running
   logic act_low_q, act_low_d; // low routine running
   logic hold_q, hold_d; // waiting one instruction after return
   logic [3:0] last_src_q, last_src_d; // last granted source
   // outputs
   tlic_pkg::tlic_grant_type grant_q, grant_d;
   tlic_pkg::tlic_apb_rsp_type rsp_q, rsp_d;
   // decode helpers
   logic [tlic_pkg::NUM_SRC-1:0] src_en; // per-source enables in query order
   logic [tlic_pkg::NUM_SRC-1:0] src_high; // per-source level in query order
   logic [tlic_pkg::NUM_SRC-1:0] elig; // eligible requests
   logic [tlic_pkg::NUM_SRC-1:0] req_high; // eligible high requests
   logic [tlic_pkg::NUM_SRC-1:0] req_low; // eligible low requests
   logic hi_found, lo_found;
   logic [3:0] hi_idx, lo_idx;
   logic wr_acc, rd_acc; // apb access phase strobes
   logic [9:0] reg_idx; // word index of the access
   logic addr_ok; // mapped and aligned

   // vector address of a source from its query number
   function automatic logic [15:0] vector_of(input logic [3:0] src);
      logic [15:0] qnum;
      qnum = (src == tlic_pkg::SRC_COMPARATOR) ? tlic_pkg::CMP_QUERY_NUM : {12'h000, src};
      vector_of = 16'(tlic_pkg::VECTOR_BASE + tlic_pkg::VECTOR_STEP * qnum);
   endfunction : vector_of

   // true for an index this block maps
   function automatic logic is_mapped(input logic [9:0] idx);
      is_mapped = (idx == tlic_pkg::IDX_ENABLE_PRIMARY) || (idx == tlic_pkg::IDX_ENABLE_SECONDARY) ||
                  (idx == tlic_pkg::IDX_LEVEL_PRIMARY) || (idx == tlic_pkg::IDX_LEVEL_SECONDARY) ||
                  (idx == tlic_pkg::IDX_FLAGS) || (idx == tlic_pkg::IDX_STATUS);
   endfunction : is_mapped

   // gather register bits into query order; reserved positions are left out
   always_comb
   begin
      src_en = {en_sec_q[tlic_pkg::SEC_CMP_BIT], en_sec_q[3:0], en_pri_q[tlic_pkg::PRI_SRC_BITS-1:0]};
      src_high = {lv_sec_q[tlic_pkg::SEC_CMP_BIT], lv_sec_q[3:0], lv_pri_q[tlic_pkg::PRI_SRC_BITS-1:0]};
      elig = flag_q & src_en & {tlic_pkg::NUM_SRC{en_pri_q[tlic_pkg::BIT_GLOBAL_IRQ_ENABLE]}};
      req_high = elig & src_high;
      req_low = elig & ~src_high;
   end

   // pick the smallest query number at each level
   tlic_pick u_pick_high
   (
      .req(req_high),
      .found(hi_found),
      .idx(hi_idx)
   );
   tlic_pick u_pick_low
   (
      .req(req_low),
      .found(lo_found),
      .idx(lo_idx)
   );

   // apb decode
   always_comb
   begin
      reg_idx = paddr[11:2];
      addr_ok = is_mapped(reg_idx) && (paddr[1:0] == 2'b00);
      wr_acc = psel && penable && pwrite && rsp_q.ready;
      rd_acc = psel && penable && !pwrite && rsp_q.ready;
   end

   // next values of registers, flags, nesting state and grant
   always_comb
   begin
      en_pri_d = en_pri_q;
      en_sec_d = en_sec_q;
      lv_pri_d = lv_pri_q;
      lv_sec_d = lv_sec_q;
      act_high_d = act_high_q;
      act_low_d = act_low_q;
      hold_d = hold_q;
      last_src_d = last_src_q;
      grant_d = grant_q;
      grant_d.take = 1'b0;
      flag_d = flag_q;
      // software writes; reserved bits are masked off
      if (wr_acc && addr_ok)
      begin
         unique case (reg_idx)
            tlic_pkg::IDX_ENABLE_PRIMARY: en_pri_d = pwdata[7:0] & tlic_pkg::MASK_ENABLE_PRIMARY;
            tlic_pkg::IDX_ENABLE_SECONDARY: en_sec_d = pwdata[7:0] & tlic_pkg::MASK_ENABLE_SECONDARY;
            tlic_pkg::IDX_LEVEL_PRIMARY: lv_pri_d = pwdata[7:0] & tlic_pkg::MASK_LEVEL_PRIMARY;
            tlic_pkg::IDX_LEVEL_SECONDARY: lv_sec_d = pwdata[7:0] & tlic_pkg::MASK_LEVEL_SECONDARY;
            // write one to clear; hardware-cleared flags ignore software
            tlic_pkg::IDX_FLAGS: flag_d = flag_d & ~(pwdata[tlic_pkg::NUM_SRC-1:0] & ~tlic_pkg::HW_CLEAR_MASK);
            default: flag_d = flag_d; // status is read only
         endcase
      end
      if (return_from_interrupt)
      begin
         // the most recent routine is the high one when both are active
         if (act_high_q)
         begin
            act_high_d = 1'b0;
         end
         else
         begin
            act_low_d = 1'b0;
         end
         hold_d = 1'b1;
      end
      else if (instr_boundary && hold_q)
      begin
         // the returned-to program runs one instruction before any grant
         hold_d = 1'b0;
      end
      else if (instr_boundary && !act_high_q && hi_found)
      begin
         // high request: taken over idle or over an active low routine
         grant_d.take = 1'b1;
         grant_d.high = 1'b1;
         grant_d.src = hi_idx;
         grant_d.vector = vector_of(hi_idx);
         act_high_d = 1'b1;
         last_src_d = hi_idx;
         flag_d[hi_idx] = flag_d[hi_idx] & ~tlic_pkg::HW_CLEAR_MASK[hi_idx];
      end
      else if (instr_boundary && !act_high_q && !act_low_q && lo_found)
      begin
         // low request only when nothing is running; otherwise it stays pending
         grant_d.take = 1'b1;
         grant_d.high = 1'b0;
         grant_d.src = lo_idx;
         grant_d.vector = vector_of(lo_idx);
         act_low_d = 1'b1;
         last_src_d = lo_idx;
         flag_d[lo_idx] = flag_d[lo_idx] & ~tlic_pkg::HW_CLEAR_MASK[lo_idx];
      end
      // a new event wins over any clear in the same cycle
      flag_d = flag_d | src_set;
   end

   // apb answer: one wait-free access phase, error on unmapped words
   always_comb
   begin
      rsp_d = rsp_q;
      rsp_d.ready = psel && !penable;
      rsp_d.slverr = psel && !penable && !(is_mapped(paddr[11:2]) && (paddr[1:0] == 2'b00));
      if (psel && !penable && !pwrite)
      begin
         unique case (paddr[11:2])
            tlic_pkg::IDX_ENABLE_PRIMARY: rsp_d.rdata = {24'h000000, en_pri_q};
            tlic_pkg::IDX_ENABLE_SECONDARY: rsp_d.rdata = {24'h000000, en_sec_q};
            tlic_pkg::IDX_LEVEL_PRIMARY: rsp_d.rdata = {24'h000000, lv_pri_q};
            tlic_pkg::IDX_LEVEL_SECONDARY: rsp_d.rdata = {24'h000000, lv_sec_q};
            tlic_pkg::IDX_FLAGS: rsp_d.rdata = {20'h00000, flag_q};
            tlic_pkg::IDX_STATUS: rsp_d.rdata = {24'h000000, last_src_q, 1'b0, hold_q, act_low_q, act_high_q};
            default: rsp_d.rdata = 32'h00000000;
         endcase
      end
      else if (rd_acc)
      begin
         // data held through the access phase, then dropped
         rsp_d.rdata = rsp_q.rdata;
      end
      else
      begin
         rsp_d.rdata = 32'h00000000;
      end
   end

   // register all state; clock enable low freezes everything
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_pri_q <= tlic_pkg::RST_ENABLE;
         en_sec_q <= tlic_pkg::RST_ENABLE;
         lv_pri_q <= tlic_pkg::RST_LEVEL;
         lv_sec_q <= tlic_pkg::RST_LEVEL;
         flag_q <= tlic_pkg::RST_FLAGS;
         act_high_q <= 1'b0;
         act_low_q <= 1'b0;
         hold_q <= 1'b0;
         last_src_q <= 4'h0;
         grant_q <= '0;
         rsp_q <= '0;
      end
      else if (clk_en)
      begin
         en_pri_q <= en_pri_d;
         en_sec_q <= en_sec_d;
         lv_pri_q <= lv_pri_d;
         lv_sec_q <= lv_sec_d;
         flag_q <= flag_d;
         act_high_q <= act_high_d;
         act_low_q <= act_low_d;
         hold_q <= hold_d;
         last_src_q <= last_src_d;
         grant_q <= grant_d;
         rsp_q <= rsp_d;
      end
   end

   // outputs straight from flip-flops
   assign prdata = rsp_q.rdata;
   assign pready = rsp_q.ready;
   assign pslverr = rsp_q.slverr;
   assign irq_take = grant_q.take;
   assign irq_high = grant_q.high;
   assign irq_src = grant_q.src;
   assign irq_vector = grant_q.vector;
   assign pending_flags = flag_q;
endmodule : tlic_core

// *** tlic_pkg.sv ***
// package for the two-level interrupt controller: register map, field layouts, reset values,
// source numbering, vector table and the carrier types shared by the design files.
// assumes the apb slave decodes a 12-bit byte address with each register on one aligned word.
package tlic_pkg;
   // number of sources and width of a source index
   localparam int unsigned NUM_SRC = 12;
   localparam int unsigned SRC_W = 4;
   // printed register indices; the byte address is four times the index
   localparam logic [9:0] IDX_ENABLE_PRIMARY = 10'h0A8;
   localparam logic [9:0] IDX_ENABLE_SECONDARY = 10'h0A9;
   localparam logic [9:0] IDX_LEVEL_PRIMARY = 10'h0B8;
   localparam logic [9:0] IDX_LEVEL_SECONDARY = 10'h0B9;
   // extra registers: pending flags and controller status
   localparam logic [9:0] IDX_FLAGS = 10'h0C0;
   localparam logic [9:0] IDX_STATUS = 10'h0C1;
   // writable bit masks; reserved positions ignore writes and read as zero
   localparam logic [7:0] MASK_ENABLE_PRIMARY = 8'hFF;
   localparam logic [7:0] MASK_ENABLE_SECONDARY = 8'h2F;
   localparam logic [7:0] MASK_LEVEL_PRIMARY = 8'h7F;
   localparam logic [7:0] MASK_LEVEL_SECONDARY = 8'h2F;
   // reset values
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_LEVEL = 8'h00;
   localparam logic [11:0] RST_FLAGS = 12'h000;
   // field positions
   localparam int unsigned BIT_GLOBAL_IRQ_ENABLE = 7;
   localparam int unsigned PRI_SRC_BITS = 7;
   localparam int unsigned SEC_CMP_BIT = 5;
   // source indices in query order
   localparam logic [3:0] SRC_EXT0 = 4'h0;
   localparam logic [3:0] SRC_TIMER0 = 4'h1;
   localparam logic [3:0] SRC_EXT1 = 4'h2;
   localparam logic [3:0] SRC_TIMER1 = 4'h3;
   localparam logic [3:0] SRC_COMPARATOR = 4'hB;
   // flags that hardware clears when the core takes the request
   localparam logic [11:0] HW_CLEAR_MASK = 12'h00F;
   // vector address = base + step * query number
   localparam logic [15:0] VECTOR_BASE = 16'h0003;
   localparam logic [15:0] VECTOR_STEP = 16'h0008;
   localparam logic [15:0] CMP_QUERY_NUM = 16'h000C;
   // status register field positions
   localparam int unsigned ST_ACT_HIGH = 0;
   localparam int unsigned ST_ACT_LOW = 1;
   localparam int unsigned ST_HOLD = 2;
   localparam int unsigned ST_LAST_SRC = 4;
   // one grant to the core
   typedef struct packed {
      logic take;
      logic high;
      logic [3:0] src;
      logic [15:0] vector;
   } tlic_grant_type;
   // apb answer
   typedef struct packed {
      logic ready;
      logic slverr;
      logic [31:0] rdata;
   } tlic_apb_rsp_type;
endpackage : tlic_pkg

// *** tlic_pick.sv ***
// fixed-order picker for the interrupt controller: finds the lowest-numbered set request.
// assumes the caller has already masked requests by enable and level.
`timescale 1ns/10ps
module tlic_pick
(
   // requests in query order
   input wire logic [tlic_pkg::NUM_SRC-1:0] req,
   // winner
   output logic found,
   output logic [tlic_pkg::SRC_W-1:0] idx
);
   // scan from the top so the smallest index is left last
   always_comb
   begin
      found = 1'b0;
      idx = '0;
      for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            found = 1'b1;
            idx = tlic_pkg::SRC_W'(i);
         end
      end
   end
endmodule : tlic_pick

// *** tlic_core_properties.sv ***
// port-level properties of tlic_core, bound below
// assumes one pclk domain and active-low async presetn
`timescale 1ns/10ps
module tlic_core_properties
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // requests and core handshake
   input wire logic [11:0] src_set,
   input wire logic instr_boundary,
   input wire logic return_from_interrupt,
   input wire logic irq_take,
   input wire logic irq_high,
   input wire logic [3:0] irq_src,
   input wire logic [15:0] irq_vector,
   input wire logic [11:0] pending_flags
);
   logic hold_q, hold_d, hi_q, hi_d, lo_q, lo_d; // return hold and active levels
   // returns pop high first, boundaries end the hold, grants open a level
   always_comb
   begin
      hold_d = hold_q;
      hi_d = hi_q;
      lo_d = lo_q;
      if (clk_en && return_from_interrupt)
      begin
         hold_d = 1'b1;
         hi_d = 1'b0;
         lo_d = lo_q && hi_q;
      end
      else if (clk_en && instr_boundary)
         hold_d = 1'b0;
      if (clk_en && irq_take && irq_high)
         hi_d = 1'b1;
      if (clk_en && irq_take && !irq_high)
         lo_d = 1'b1;
   end
   // helper registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_q <= 1'b0;
         hi_q <= 1'b0;
         lo_q <= 1'b0;
      end
      else
      begin
         hold_q <= hold_d;
         hi_q <= hi_d;
         lo_q <= lo_d;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_take_at_boundary; irq_take |-> $past(instr_boundary) && !$past(return_from_interrupt); endproperty
   a_take_at_boundary: assert property (p_take_at_boundary) else $error("grant off a boundary");
   property p_after_return; irq_take |-> !$past(hold_q); endproperty
   a_after_return: assert property (p_after_return) else $error("grant right after return");
   property p_no_equal; irq_take |-> !hi_q && (irq_high || !lo_q); endproperty
   a_no_equal: assert property (p_no_equal) else $error("equal or lower level preempted");
   property p_vector;
      irq_take |-> irq_vector == ((irq_src == 4'hB) ? 16'h0063 : 16'h0003 + {9'h000, irq_src, 3'h0});
   endproperty
   a_vector: assert property (p_vector) else $error("wrong vector");
   property p_flag_cause; irq_take |-> (($past(pending_flags) >> irq_src) & 12'h001) != 12'h000; endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("grant without flag");
   property p_hw_clear;
      irq_take && irq_src < 4'h4 && (($past(src_set) >> irq_src) & 12'h001) == 12'h000 |-> !pending_flags[irq_src];
   endproperty
   a_hw_clear: assert property (p_hw_clear) else $error("flag not cleared on grant");
   property p_ready; psel && !penable && clk_en |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready in access cycle");
   property p_unmapped;
      psel && !penable && clk_en && !(paddr inside {12'h2A0, 12'h2A4, 12'h2E0, 12'h2E4, 12'h300, 12'h304})
         |=> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   c_high: cover property (irq_take && irq_high);
   c_nested: cover property (irq_take && lo_q);
   c_error: cover property (pslverr);
endmodule : tlic_core_properties
bind tlic_core tlic_core_properties i_props (.pclk, .presetn, .clk_en, .psel, .penable, .paddr, .pready,
   .pslverr, .src_set, .instr_boundary, .return_from_interrupt, .irq_take, .irq_high, .irq_src, .irq_vector,
   .pending_flags);

// *** tlic_cpu_model.sv ***
// behavioural cpu core: instruction boundaries, returns, pc stack
// assumes the grant carrier is sampled on the pclk rising edge
`timescale 1ns/10ps
module tlic_cpu_model
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench control
   input wire logic run,
   input wire logic slow,
   input wire logic ret_req,
   // grant from the controller
   input wire tlic_pkg::tlic_grant_type grant,
   // strobes to the controller
   output logic instr_boundary,
   output logic return_from_interrupt,
   // program counter and nesting depth
   output logic [15:0] pc_q,
   output logic [1:0] depth_q
);
   logic [1:0] cnt_q, cnt_d, depth_d; // pace counter, next depth
   logic [15:0] pc_d;
   logic [15:0] stk_q [2]; // two-level return stack
   logic [15:0] stk_d [2];
   logic bnd_q, bnd_d, ret_q, ret_d, tick;
   assign instr_boundary = bnd_q;
   assign return_from_interrupt = ret_q;
   // pace instructions, push on grant, pop on return
   always_comb
   begin
      tick = run && (!slow || cnt_q == 2'h2);
      cnt_d = (tick || !run) ? 2'h0 : cnt_q + 2'h1;
      ret_d = tick && ret_req && !ret_q && depth_q != 2'h0;
      bnd_d = tick && !ret_d;
      pc_d = bnd_q ? pc_q + 16'h0001 : pc_q;
      stk_d = stk_q;
      depth_d = depth_q;
      if (grant.take)
      begin
         stk_d[depth_q[0]] = pc_d;
         pc_d = grant.vector;
         depth_d = depth_q + 2'h1;
      end
      else if (ret_q)
      begin
         pc_d = stk_q[~depth_q[0]];
         depth_d = depth_q - 2'h1;
      end
   end
   // register the core state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 2'h0;
         depth_q <= 2'h0;
         pc_q <= 16'h0100;
         stk_q <= '{16'h0000, 16'h0000};
         bnd_q <= 1'b0;
         ret_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         depth_q <= depth_d;
         pc_q <= pc_d;
         stk_q <= stk_d;
         bnd_q <= bnd_d;
         ret_q <= ret_d;
      end
   end
endmodule : tlic_cpu_model

// *** tb_tlic_core.sv ***
// self-checking bench for tlic_core against a behavioural cpu core
// assumes 20 MHz pclk; the checker is attached by bind
`timescale 1ns/10ps
module tb_tlic_core;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, src_set, pending_flags;
   logic [31:0] pwdata, prdata;
   logic run, slow, ret_req, instr_boundary, return_from_interrupt, irq_take, irq_high;
   logic [3:0] irq_src;
   logic [15:0] irq_vector, pc;
   logic [1:0] depth;
   tlic_pkg::tlic_grant_type grant;
   int n_fail, checks_done, n_take;
   assign grant = {irq_take, irq_high, irq_src, irq_vector};
   tlic_core i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .src_set, .instr_boundary, .return_from_interrupt, .irq_take, .irq_high, .irq_src,
      .irq_vector, .pending_flags);
   tlic_cpu_model i_cpu (.pclk, .presetn, .run, .slow, .ret_req, .grant, .instr_boundary,
      .return_from_interrupt, .pc_q(pc), .depth_q(depth));
   // 50 ns clock
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // count grants
   always @(posedge pclk)
   begin
      if (irq_take === 1'b1)
         n_take++;
   end
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // a wait ran out
   task automatic hung(input string name);
      chk(name, 32'h1, 32'h0);
      results();
   endtask : hung
   // one apb transfer, checked
   task automatic io(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
      input logic eerr);
      int i;
      // setup cycle: request and its qualifiers change just after an edge
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // access phase: hold everything until pready is seen high at a rising edge
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
         hung("pready wait");
      // answer taken at that same edge, then the request is released
      if (!wr)
         chk("prdata", exp, prdata);
      chk("pslverr", {31'h0, eerr}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : io
   // one-cycle request pulse
   task automatic pulse(input logic [11:0] m);
      @(posedge pclk);
      src_set <= m;
      @(posedge pclk);
      src_set <= 12'h000;
   endtask : pulse
   // wait for a grant and check it
   task automatic take(input logic [3:0] s, input logic h);
      int i;
      @(negedge pclk);
      for (i = 0; i < 200 && irq_take !== 1'b1; i++)
         @(negedge pclk);
      if (i == 200)
         hung("grant wait");
      chk("irq_src", {28'h0, s}, {28'h0, irq_src});
      chk("irq_high", {31'h0, h}, {31'h0, irq_high});
      chk("irq_vector", (s == 4'hB) ? 32'h63 : 32'h3 + 32'(s) * 32'h8, {16'h0, irq_vector});
      @(negedge pclk);
      chk("pc", {16'h0, irq_vector}, {16'h0, pc});
   endtask : take
   // make the core execute a return
   task automatic ret;
      int i;
      logic [1:0] dep;
      @(posedge pclk);
      dep = depth;
      ret_req <= 1'b1;
      for (i = 0; i < 50 && return_from_interrupt !== 1'b1; i++)
         @(negedge pclk);
      if (i == 50)
         hung("return wait");
      @(posedge pclk);
      ret_req <= 1'b0;
      // the core has popped one level by now
      @(negedge pclk);
      chk("depth after return", {30'h0, dep - 2'h1}, {30'h0, depth});
   endtask : ret
   // reset values, writable masks, unmapped access
   task automatic t_regs;
      logic [11:0] a [4] = '{12'h2A0, 12'h2A4, 12'h2E0, 12'h2E4};
      logic [7:0] m [4] = '{8'hFF, 8'h2F, 8'h7F, 8'h2F};
      for (int k = 0; k < 4; k++)
      begin
         io(1'b0, a[k], 32'h0, 32'h0, 1'b0);
         io(1'b1, a[k], 32'hFFFFFFFF, 32'h0, 1'b0);
         io(1'b0, a[k], 32'h0, {24'h0, m[k]}, 1'b0);
         io(1'b1, a[k], 32'h0, 32'h0, 1'b0);
      end
      io(1'b0, 12'h3FC, 32'h0, 32'h0, 1'b1);
   endtask : t_regs
   // all twelve pending at one level: query order, flag clearing
   task automatic t_order;
      io(1'b1, 12'h2A0, 32'hFF, 32'h0, 1'b0);
      io(1'b1, 12'h2A4, 32'h2F, 32'h0, 1'b0);
      pulse(12'hFFF);
      for (int k = 0; k < 12; k++)
      begin
         take(k[3:0], 1'b0);
         chk("flag kept", {31'h0, k > 3}, {31'h0, pending_flags[k]});
         if (k > 3)
            io(1'b1, 12'h300, 32'h1 << k, 32'h0, 1'b0);
         ret();
      end
   endtask : t_order
   // slow core: high preempts low, equal levels wait
   task automatic t_nest;
      @(posedge pclk);
      slow <= 1'b1;
      io(1'b1, 12'h2E4, 32'h20, 32'h0, 1'b0);
      pulse(12'h004);
      take(4'h2, 1'b0);
      pulse(12'h801);
      take(4'hB, 1'b1);
      chk("depth", 32'h2, {30'h0, depth});
      // comparator flag is software cleared; left set it would be granted again
      io(1'b1, 12'h300, 32'h800, 32'h0, 1'b0);
      pulse(12'h008);
      ret();
      ret();
      take(4'h0, 1'b0);
      ret();
      take(4'h3, 1'b0);
      ret();
      io(1'b1, 12'h2E4, 32'h0, 32'h0, 1'b0);
      slow <= 1'b0;
   endtask : t_nest
   // global and own enable gate a pending request
   task automatic t_mask;
      int n;
      io(1'b1, 12'h2A0, 32'h7F, 32'h0, 1'b0);
      pulse(12'h010);
      @(negedge pclk);
      n = n_take;
      repeat (20) @(negedge pclk);
      chk("grants", n, n_take);
      io(1'b1, 12'h2A0, 32'hEF, 32'h0, 1'b0);
      @(negedge pclk);
      repeat (20) @(negedge pclk);
      chk("grants", n, n_take);
      io(1'b1, 12'h2A0, 32'h90, 32'h0, 1'b0);
      take(4'h4, 1'b0);
      // clear the serial flag so nothing is granted again after the return
      io(1'b1, 12'h300, 32'h010, 32'h0, 1'b0);
      ret();
   endtask : t_mask
   // main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, slow, ret_req} = 6'h00;
      {clk_en, run} = 2'h3;
      {paddr, src_set, pwdata} = 56'h0;
      {n_fail, checks_done, n_take} = {32'h0, 32'h0, 32'h0};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_order();
      t_nest();
      t_mask();
      results();
   end
endmodule : tb_tlic_core
